// [hdl/discrete_sensor_spi_readout.sv]
// How it works
// - Mode bit 0 enables pull-down and uses supply low/high comparator results.
// - Mode bit 1 enables pull-up and uses ground low/high comparator results.
// - Output sets above high threshold, clears below low threshold, else holds.
// - Self-test mode follows configuration bit 9.
// - In self-test each high result is forced to its mode bit, each low result to its inverse.
// - Debounce on: sample every 60 ms, update only when two samples agree.
// - Threshold word holds four 6-bit codes at fixed bit fields.
// - SPI mode 0; input sampled and output advanced on rising clock.
// - MSB first; chip select rising ends transfer and resets serial logic.
// - Write commits only after 8 clocks; partial content then still latched.
// - Serial output undriven while chip select high; no minimum clock rate.
// - Channels stay disabled until configuration has been written.
// - Select pins choose configuration, threshold or data target.
// - Chip select falling in data mode latches sensors, shows bit 8.
// - Data read shifts serial input into data register, top bit first.
// - Configuration shifts self-test bit first, then channels 8 down to 1.
// - Any sensor output change drives the interrupt low for 1 us.
// - Reset clears the serial, configuration, threshold and sensor registers and leaves sense inputs undriven.
module discrete_sensor_spi_readout #(
  parameter int DEBOUNCE_CYCLES = sensor_readout_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic master_reset_pin_b,
  // SPI pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic function_select_lo,
  input wire logic function_select_hi,
  // Mode pins
  input wire logic debounce_enable_pin,
  // Analog comparator results per channel
  input wire logic [7:0] gnd_above_high,
  input wire logic [7:0] gnd_below_low,
  input wire logic [7:0] sup_above_high,
  input wire logic [7:0] sup_below_low,
  // Sense network and threshold DAC controls
  output logic [7:0] pull_up_enable,
  output logic [7:0] pull_down_enable,
  output logic [5:0] ground_low_code,
  output logic [5:0] ground_high_code,
  output logic [5:0] supply_low_code,
  output logic [5:0] supply_high_code,
  // Open-drain interrupt
  output logic int_out,
  output logic int_oe
);

  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 39;
  logic [NSYNC-1:0] pin_meta;
  logic [NSYNC-1:0] pin_sync;
  wire [NSYNC-1:0] pin_raw = {master_reset_pin_b, sck, cs_b, si, function_select_lo, function_select_hi,
                              debounce_enable_pin, gnd_above_high, gnd_below_low, sup_above_high,
                              sup_below_low};

  // Reset to idle pin levels (select and master reset high), so release makes no false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta <= 39'h50_0000_0000;
      pin_sync <= 39'h50_0000_0000;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire mr_s = pin_sync[38];
  wire sck_s = pin_sync[37];
  wire cs_s = pin_sync[36];
  wire si_s = pin_sync[35];
  wire sel_lo_s = pin_sync[34];
  wire sel_hi_s = pin_sync[33];
  wire debounce_enable_pin_s = pin_sync[32];
  wire [7:0] g_above = pin_sync[31:24];
  wire [7:0] g_below = pin_sync[23:16];
  wire [7:0] s_above = pin_sync[15:8];
  wire [7:0] s_below = pin_sync[7:0];

  wire hw_reset = !rst_b || !mr_s;

  // ==========================================================
  // Serial clock and select edges
  logic sck_q;
  logic cs_q;
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      cs_q <= cs_s;
    end
  end
  wire sck_rise = sck_s && !sck_q && !cs_s;
  wire cs_fall = !cs_s && cs_q;
  wire cs_rise = cs_s && !cs_q;

  // ==========================================================
  // Registers
  logic [8:0] config_reg;
  logic [23:0] threshold;
  logic configured;
  logic [7:0] sensor_state;
  logic [23:0] shift_reg;
  logic [5:0] bit_count;
  sensor_readout_pkg::target_e target;
  logic [23:0] next_shift;
  sensor_readout_pkg::target_e next_target;

  wire [7:0] mode_bits = config_reg[7:0];
  wire self_test = config_reg[sensor_readout_pkg::CFG_SELF_TEST_POS];

  // Target decode: lower select pin wins over upper
  assign next_target = sel_lo_s ? sensor_readout_pkg::TGT_DATA :
                       sel_hi_s ? sensor_readout_pkg::TGT_THRESH : sensor_readout_pkg::TGT_CONFIG;

  // Shift path; each target shifts only within its own width, MSB first
  always_comb begin
    next_shift = shift_reg;
    if (cs_fall) begin
      case (next_target)
        sensor_readout_pkg::TGT_CONFIG: next_shift = {15'h0000, config_reg};
        sensor_readout_pkg::TGT_THRESH: next_shift = threshold;
        sensor_readout_pkg::TGT_DATA: next_shift = {16'h0000, sensor_state};
        default: next_shift = shift_reg;
      endcase
    end else if (sck_rise) begin
      case (target)
        sensor_readout_pkg::TGT_CONFIG: next_shift = {15'h0000, shift_reg[7:0], si_s};
        sensor_readout_pkg::TGT_THRESH: next_shift = {shift_reg[22:0], si_s};
        sensor_readout_pkg::TGT_DATA: next_shift = {16'h0000, shift_reg[6:0], si_s};
        default: next_shift = shift_reg;
      endcase
    end
  end

  // Serial state; fully edge driven so any slow clock rate works
  always_ff @(posedge clk) begin
    if (hw_reset || cs_rise) begin
      shift_reg <= 24'h00_0000;
      bit_count <= 6'h00;
    end else begin
      shift_reg <= next_shift;
      if (cs_fall) begin
        bit_count <= 6'h00;
      end else if (sck_rise && bit_count != 6'h3f) begin
        bit_count <= bit_count + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (hw_reset) begin
      target <= sensor_readout_pkg::TGT_CONFIG;
    end else if (cs_fall) begin
      target <= next_target;
    end
  end

  // Commit on select rising; short bursts are taken as noise
  wire commit = cs_rise && (bit_count >= sensor_readout_pkg::MIN_COMMIT_CLOCKS);
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      config_reg <= sensor_readout_pkg::CFG_RESET;
      threshold <= sensor_readout_pkg::THR_RESET;
      configured <= 1'b0;
    end else if (commit && target == sensor_readout_pkg::TGT_CONFIG) begin
      config_reg <= shift_reg[8:0];
      configured <= 1'b1;
    end else if (commit && target == sensor_readout_pkg::TGT_THRESH) begin
      threshold <= shift_reg;
    end
  end

  // Serial output from a flop; undriven while deselected
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= !cs_s;
      case (target == next_target || !cs_fall ? target : next_target)
        sensor_readout_pkg::TGT_CONFIG: so <= next_shift[8];
        sensor_readout_pkg::TGT_THRESH: so <= next_shift[23];
        sensor_readout_pkg::TGT_DATA: so <= next_shift[7];
        default: so <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Sense network and DAC codes
  assign pull_up_enable = configured ? mode_bits : 8'h00;
  assign pull_down_enable = configured ? ~mode_bits : 8'h00;
  assign ground_low_code = threshold[sensor_readout_pkg::THR_GND_LOW_LSB +: 6];
  assign ground_high_code = threshold[sensor_readout_pkg::THR_GND_HIGH_LSB +: 6];
  assign supply_low_code = threshold[sensor_readout_pkg::THR_SUP_LOW_LSB +: 6];
  assign supply_high_code = threshold[sensor_readout_pkg::THR_SUP_HIGH_LSB +: 6];

  // Comparator selection by mode; self-test forces the result
  wire [7:0] mode_above = (mode_bits & g_above) | (~mode_bits & s_above);
  wire [7:0] mode_below = (mode_bits & g_below) | (~mode_bits & s_below);
  wire [7:0] cmp_above = self_test ? mode_bits : mode_above;
  wire [7:0] cmp_below = self_test ? ~mode_bits : mode_below;

  // Hysteresis; a disabled channel reads low
  logic [7:0] cmp_state;
  always_ff @(posedge clk) begin
    if (hw_reset || !configured) begin
      cmp_state <= 8'h00;
    end else begin
      cmp_state <= cmp_above | (cmp_state & ~cmp_below);
    end
  end

  // ==========================================================
  // Debounce sampler
  logic [31:0] debounce_enable_pin_timer;
  logic [7:0] last_sample;
  wire debounce_enable_pin_tick = debounce_enable_pin_timer == 32'(DEBOUNCE_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (hw_reset || debounce_enable_pin_tick) begin
      debounce_enable_pin_timer <= 32'h0000_0000;
    end else begin
      debounce_enable_pin_timer <= debounce_enable_pin_timer + 32'h0000_0001;
    end
  end

  // Agreement is judged between the previous and the current sample
  wire [7:0] agree = ~(cmp_state ^ last_sample);
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      last_sample <= 8'h00;
      sensor_state <= sensor_readout_pkg::DATA_RESET;
    end else if (!debounce_enable_pin_s) begin
      last_sample <= cmp_state;
      sensor_state <= cmp_state;
    end else if (debounce_enable_pin_tick) begin
      last_sample <= cmp_state;
      sensor_state <= (agree & cmp_state) | (~agree & sensor_state);
    end
  end

  // ==========================================================
  // Interrupt pulse
  logic [7:0] state_q;
  logic [5:0] int_count;
  wire state_changed = state_q != sensor_state;
  always_ff @(posedge clk) begin
    if (hw_reset) begin
      state_q <= 8'h00;
      int_count <= 6'h00;
    end else begin
      state_q <= sensor_state;
      if (state_changed) begin
        int_count <= 6'(sensor_readout_pkg::INT_PULSE_CYCLES);
      end else if (int_count != 6'h00) begin
        int_count <= int_count - 6'h01;
      end
    end
  end
  assign int_out = 1'b0;
  assign int_oe = int_count != 6'h00;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (hw_reset);

  property p_unconfigured_off;
    !configured |-> pull_up_enable == 8'h00 && pull_down_enable == 8'h00 && cmp_state == 8'h00;
  endproperty
  a_unconfigured_off: assert property (p_unconfigured_off) else $error("channel active before config");

  property p_pull_paths;
    configured |-> (pull_up_enable == mode_bits) && (pull_down_enable == ~pull_up_enable);
  endproperty
  a_pull_paths: assert property (p_pull_paths) else $error("pull path mismatch");

  property p_hyst_set;
    configured ##1 configured |-> (cmp_state & $past(cmp_above)) == $past(cmp_above);
  endproperty
  a_hyst_set: assert property (p_hyst_set) else $error("output not set above high");

  property p_self_test;
    (configured && self_test && $stable(config_reg)) [*2] |-> cmp_state == mode_bits;
  endproperty
  a_self_test: assert property (p_self_test) else $error("self-test pattern missing");

  property p_no_debounce;
    !debounce_enable_pin_s |=> sensor_state == $past(cmp_state);
  endproperty
  a_no_debounce: assert property (p_no_debounce) else $error("data not following comparator");

  property p_debounce_hold;
    debounce_enable_pin_s && !debounce_enable_pin_tick |=> $stable(sensor_state);
  endproperty
  a_debounce_hold: assert property (p_debounce_hold) else $error("data moved between samples");

  property p_so_idle;
    cs_s ##1 cs_s |-> !so_oe;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("serial output driven while deselected");

  property p_data_latch;
    cs_fall && sel_lo_s |=> shift_reg[7:0] == $past(sensor_state) && so == $past(sensor_state[7]);
  endproperty
  a_data_latch: assert property (p_data_latch) else $error("data not latched at select");

  property p_short_ignored;
    cs_rise && bit_count < 6'h08 |=> $stable(config_reg) && $stable(threshold);
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short burst committed");

  property p_int_pulse;
    state_changed |=> int_oe [*8];
  endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("interrupt pulse too short");

  c_config_write: cover property (commit && target == sensor_readout_pkg::TGT_CONFIG);
  c_thresh_write: cover property (commit && target == sensor_readout_pkg::TGT_THRESH);
  c_data_read: cover property (cs_fall && sel_lo_s ##[1:1000] cs_rise);
  c_interrupt: cover property ($rose(int_oe));

endmodule

// [hdl/sensor_readout_pkg.sv]
package sensor_readout_pkg;

  // ==========================================================
  // Widths
  localparam int CHANNELS = 8;
  localparam int CFG_WIDTH = 9;
  localparam int THR_WIDTH = 24;
  localparam int DATA_WIDTH = 8;
  localparam int CODE_WIDTH = 6;
  localparam int COUNT_WIDTH = 6;

  // ==========================================================
  // Field positions
  localparam int CFG_SELF_TEST_POS = 8;
  localparam int THR_GND_LOW_LSB = 18;
  localparam int THR_GND_HIGH_LSB = 12;
  localparam int THR_SUP_LOW_LSB = 6;
  localparam int THR_SUP_HIGH_LSB = 0;

  // ==========================================================
  // Reset values
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 9'h000;
  localparam logic [THR_WIDTH-1:0] THR_RESET = 24'h00_0000;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEBOUNCE_MS = 60;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int INT_PULSE_NS = 1000;
  localparam int INT_PULSE_CYCLES = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [COUNT_WIDTH-1:0] MIN_COMMIT_CLOCKS = 6'h08;

  // ==========================================================
  // Serial targets, Gray coded
  typedef enum logic [1:0] {
    TGT_CONFIG = 2'b00,
    TGT_THRESH = 2'b01,
    TGT_DATA = 2'b11
  } target_e;

endpackage

// [verif/spi_host_model.sv]
// ==========================================================
// Host side of the serial link, mode 0
module spi_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sck,
  output logic cs_b,
  output logic si,
  output logic sel_lo,
  output logic sel_hi,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: clock low, not selected
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
  end

  // Whole cycles, then step off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One framed transfer, MSB first; so is taken just before each rise
  // Half periods of 4 cycles give the 160 ns link clock
  task automatic xfer(input logic [1:0] sel, input int n, input logic [31:0] wd, output logic [31:0] rd);
    rd = '0;
    {sel_hi, sel_lo} = sel;
    wait_clk(1);
    cs_b = 1'b0;
    wait_clk(8);
    for (int i = n - 1; i >= 0; i--) begin
      // Bits beyond the word send zeros, the share of chained devices
      si = (i < 32) ? wd[i] : 1'b0;
      wait_clk(4);
      rd = {rd[30:0], so};
      sck = 1'b1;
      wait_clk(4);
      sck = 1'b0;
    end
    wait_clk(4);
    // Select held low for the whole frame, so nothing is re-latched
    cs_b = 1'b1;
    si = ~si;
    wait_clk(8);
  endtask
endmodule

// [verif/testbench.sv]
// ==========================================================
// Self-checking bench for the sensor readout
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // Short debounce period keeps the run brief
  localparam int DEB = 200;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, si, so, so_oe, sel_lo, sel_hi;
  logic deb = 1'b0;
  logic mr_b = 1'b1;
  logic so_line;
  logic [7:0] g_hi = 8'h00, g_lo = 8'h00, s_hi = 8'h00, s_lo = 8'h00;
  logic [7:0] pu, pd;
  logic [5:0] c_gl, c_gh, c_sl, c_sh;
  logic int_out, int_oe;
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  // Undriven output floats; show the inverse so a late enable is caught
  assign so_line = so_oe ? so : ~so;

  discrete_sensor_spi_readout #(.DEBOUNCE_CYCLES(DEB)) u_discrete_sensor_spi_readout (
    .clk(clk), .rst_b(rst_b), .master_reset_pin_b(mr_b),
    .sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe),
    .function_select_lo(sel_lo), .function_select_hi(sel_hi),
    .debounce_enable_pin(deb),
    .gnd_above_high(g_hi), .gnd_below_low(g_lo), .sup_above_high(s_hi), .sup_below_low(s_lo),
    .pull_up_enable(pu), .pull_down_enable(pd),
    .ground_low_code(c_gl), .ground_high_code(c_gh), .supply_low_code(c_sl), .supply_high_code(c_sh),
    .int_out(int_out), .int_oe(int_oe)
  );

  spi_host_model u_spi_host_model (
    .clk(clk), .sck(sck), .cs_b(cs_b), .si(si), .sel_lo(sel_lo), .sel_hi(sel_hi), .so(so_line)
  );

  // ==========================================================
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Nine clocks: eight sensor bits, then the first bit shifted in
  task automatic read_data(input logic [1:0] sel, input logic [7:0] exp);
    u_spi_host_model.xfer(sel, 9, 32'h0000_0100, rd);
    chk("data", {23'h00_0000, exp, 1'b1}, rd);
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("pull_up", 32'h0, {24'h0, pu});
    chk("pull_down", 32'h0, {24'h0, pd});
    chk("codes", 32'h0, {8'h0, c_gl, c_gh, c_sl, c_sh});
    chk("so_oe idle", 32'h0, {31'h0, so_oe});
  endtask

  // Short frames are dropped; exactly eight clocks commit
  task automatic t_config();
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_00F0, rd);
    chk("pull_up", 32'hF0, {24'h0, pu});
    chk("pull_down", 32'h0F, {24'h0, pd});
    u_spi_host_model.xfer(2'b00, 7, 32'h0000_007F, rd);
    chk("pull_up short", 32'hF0, {24'h0, pu});
    u_spi_host_model.xfer(2'b00, 8, 32'h0000_00C3, rd);
    chk("cfg readback", 32'h0000_0078, rd);
    chk("pull_up eight", 32'hC3, {24'h0, pu});
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_00F0, rd);
    chk("so_oe after frame", 32'h0, {31'h0, so_oe});
  endtask

  task automatic t_thresh();
    u_spi_host_model.xfer(2'b10, 24, 32'h004E_F7BA, rd);
    chk("gnd_low", 32'h13, {26'h0, c_gl});
    chk("gnd_high", 32'h2F, {26'h0, c_gh});
    chk("sup_low", 32'h1E, {26'h0, c_sl});
    chk("sup_high", 32'h3A, {26'h0, c_sh});
    u_spi_host_model.xfer(2'b10, 24, 32'h004E_F7BA, rd);
    chk("thr readback", 32'h004E_F7BA, rd);
    // One chained device behind: 48 clocks, the last 24 bits stay here
    u_spi_host_model.xfer(2'b10, 48, 32'hC312_3456, rd);
    chk("chain pass-through", 32'hBA00_00C3, rd);
    chk("chain codes", 32'h0012_3456, {8'h0, c_gl, c_gh, c_sl, c_sh});
  endtask

  // Pin reset clears config and thresholds; channels wait for a fresh config
  task automatic t_master_reset();
    mr_b = 1'b0;
    step(4);
    chk("pull_up in reset", 32'h0, {24'h0, pu});
    chk("codes in reset", 32'h0, {8'h0, c_gl, c_gh, c_sl, c_sh});
    mr_b = 1'b1;
    step(4);
    chk("pull_down after reset", 32'h0, {24'h0, pd});
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_00F0, rd);
    chk("pull_up reconfig", 32'hF0, {24'h0, pu});
  endtask

  // Mode bits pick which comparator pair counts; outputs hold between thresholds
  task automatic t_sense();
    g_hi = 8'h3C;
    s_hi = 8'hC3;
    step(6);
    chk("int_oe", 32'h1, {31'h0, int_oe});
    chk("int_out", 32'h0, {31'h0, int_out});
    read_data(2'b11, 8'h33);
    chk("int_oe end", 32'h0, {31'h0, int_oe});
    g_hi = 8'h00;
    s_hi = 8'h00;
    step(4);
    read_data(2'b11, 8'h33);
    g_lo = 8'hFF;
    s_lo = 8'hFF;
    step(4);
    read_data(2'b11, 8'h00);
  endtask

  // Written pattern comes back as data while the test bit is set
  task automatic t_selftest();
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_01A5, rd);
    read_data(2'b01, 8'hA5);
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_0100, rd);
    u_spi_host_model.xfer(2'b00, 9, 32'h0000_00F0, rd);
    read_data(2'b01, 8'h00);
  endtask

  // A change needs two agreeing samples, so it lands after one to two periods
  task automatic t_debounce();
    deb = 1'b1;
    step(4);
    g_lo = 8'h00;
    s_lo = 8'h00;
    g_hi = 8'hFF;
    s_hi = 8'hFF;
    step(2);
    read_data(2'b11, 8'h00);
    step(2 * DEB + 50);
    read_data(2'b11, 8'hFF);
  endtask

  // ==========================================================
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("unexpected timeout: expected done, seen running");
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    step(4);
    t_reset();
    t_config();
    t_thresh();
    t_sense();
    t_selftest();
    t_debounce();
    t_master_reset();
    end_of_test();
  end
endmodule
